// ---- logic/clock_ratio_defines.svh ----
// Strap decode constants for the power-up clock ratio block
`ifndef CLOCK_RATIO_DEFINES_SVH
`define CLOCK_RATIO_DEFINES_SVH
// Platform bus to system clock strap codes
`define PB_CODE_4_1   3'h0
`define PB_CODE_5_1   3'h1
`define PB_CODE_6_1   3'h2
`define PB_CODE_8_1   3'h3
`define PB_CODE_10_1  3'h4
`define PB_CODE_12_1  3'h5
// Core to platform bus strap codes
`define CORE_CODE_3_2 3'h3
`define CORE_CODE_2_1 3'h4
`define CORE_CODE_5_2 3'h5
`define CORE_CODE_3_1 3'h6
`define CORE_CODE_7_2 3'h7
// Ratios as numerator over denominator, 5-bit numerator, 2-bit denominator
`define PB_NUM_RESET   5'h00
`define CORE_NUM_RESET 5'h00
`define DEN_RESET      2'h0
`endif

// ---- logic/clock_ratio_pkg.sv ----
// Types for the power-up clock ratio block
package clock_ratio_pkg;
	typedef struct packed {
		logic [4:0] num;
		logic [1:0] den;
		logic       reserved;
	} ratio_t;
	typedef struct packed {
		logic [2:0] local_address_strap_bits;
		logic       bus_control_strap;
		logic       address_latch_enable_strap;
		logic       general_purpose_line2_strap;
	} straps_t;
	typedef enum logic [1:0] {
		ST_RESET   = 2'b00,
		ST_SETTLE  = 2'b01,
		ST_LOCKED  = 2'b10
	} cap_state_t;
endpackage

// ---- logic/power_up_clock_ratio_straps.sv ----
// Power-up strap capture and clock ratio decode
//
// Behaviour
// [R1] Local address straps 000..101 give platform bus ratios 4,5,6,8,10,12 to 1; 110/111 reserved.
// [R2] First core code is bus control, address latch enable, general purpose line 2, msb first.
// [R3] Core code 011..111 gives 3:2, 2:1, 5:2, 3:1, 7:2; 000..010 reserved.
// [R4] Each core has its own ratio; the second core ratio comes from its own strap code input.
// [R5] Straps are captured during reset and the ratios stay fixed after release.
// [R6] Board must not pull the listed status outputs low during power-on reset.
// [R7] Board holds the test select input at its defined level through configuration.
// [R8] Board never presents a reserved code on either strap group; the bench drives 110/111 and 000..010 to test the reserved flags.
`timescale 1ns/100ps
`include "clock_ratio_defines.svh"
module power_up_clock_ratio_straps
	import clock_ratio_pkg::*;
(
	input  wire logic       CLK_SYS,
	input  wire logic       SRST,
	input  wire logic [2:0] LOCAL_ADDRESS_STRAP_BITS,
	input  wire logic       BUS_CONTROL_STRAP,
	input  wire logic       ADDRESS_LATCH_ENABLE_STRAP,
	input  wire logic       GENERAL_PURPOSE_LINE2_STRAP,
	input  wire logic [2:0] CORE1_RATIO_STRAP,
	output logic      [4:0] PB_RATIO_NUM,
	output logic            PB_RATIO_RESERVED,
	output logic      [4:0] CORE0_RATIO_NUM,
	output logic      [1:0] CORE0_RATIO_DEN,
	output logic            CORE0_RATIO_RESERVED,
	output logic      [4:0] CORE1_RATIO_NUM,
	output logic      [1:0] CORE1_RATIO_DEN,
	output logic            CORE1_RATIO_RESERVED,
	output logic            RATIOS_LOCKED
);
	// ****************************************
	// Functions
	// ****************************************
	function automatic ratio_t pb_decode(input logic [2:0] code);
		ratio_t r;
		r = '{num: 5'h00, den: 2'h1, reserved: 1'b0};
		unique case (code) // R1
			`PB_CODE_4_1:  r.num = 5'h04;
			`PB_CODE_5_1:  r.num = 5'h05;
			`PB_CODE_6_1:  r.num = 5'h06;
			`PB_CODE_8_1:  r.num = 5'h08;
			`PB_CODE_10_1: r.num = 5'h0a;
			`PB_CODE_12_1: r.num = 5'h0c;
			default:       r.reserved = 1'b1;
		endcase
		return r;
	endfunction

	function automatic ratio_t core_decode(input logic [2:0] code);
		ratio_t r;
		r = '{num: 5'h00, den: 2'h1, reserved: 1'b0};
		unique case (code) // R3
			`CORE_CODE_3_2: begin
				r.num = 5'h03;
				r.den = 2'h2;
			end
			`CORE_CODE_2_1: r.num = 5'h02;
			`CORE_CODE_5_2: begin
				r.num = 5'h05;
				r.den = 2'h2;
			end
			`CORE_CODE_3_1: r.num = 5'h03;
			`CORE_CODE_7_2: begin
				r.num = 5'h07;
				r.den = 2'h2;
			end
			default:        r.reserved = 1'b1;
		endcase
		return r;
	endfunction

	// ****************************************
	// Strap synchronisers
	// ****************************************
	// Straps are pins, so two stages before any decode
	logic [8:0] sync1_reg;
	logic [8:0] sync2_reg;
	logic [8:0] sync1_next;
	logic [8:0] sync2_next;
	always_comb begin
		sync1_next = {LOCAL_ADDRESS_STRAP_BITS, BUS_CONTROL_STRAP,
			ADDRESS_LATCH_ENABLE_STRAP, GENERAL_PURPOSE_LINE2_STRAP, CORE1_RATIO_STRAP};
		sync2_next = sync1_reg;
	end
	always_ff @(posedge CLK_SYS) begin
		sync1_reg <= sync1_next;
		sync2_reg <= sync2_next;
	end

	straps_t    straps;
	logic [2:0] core0_code;
	logic [2:0] core1_code;
	always_comb begin
		straps = straps_t'(sync2_reg[8:3]);
		core0_code = {straps.bus_control_strap, straps.address_latch_enable_strap,
			straps.general_purpose_line2_strap}; // R2
		core1_code = sync2_reg[2:0];
	end

	// ****************************************
	// Capture control
	// ****************************************
	// Sample continuously while reset is held; freeze at the first edge after release
	cap_state_t state_reg;
	cap_state_t state_next;
	ratio_t     pb_reg;
	ratio_t     pb_next;
	ratio_t     c0_reg;
	ratio_t     c0_next;
	ratio_t     c1_reg;
	ratio_t     c1_next;
	ratio_t     pb_dec;
	ratio_t     c0_dec;
	ratio_t     c1_dec;
	always_comb begin
		pb_dec = pb_decode(straps.local_address_strap_bits);
		c0_dec = core_decode(core0_code);
		c1_dec = core_decode(core1_code); // R4
		state_next = state_reg;
		pb_next = pb_reg;
		c0_next = c0_reg;
		c1_next = c1_reg;
		unique case (state_reg)
			ST_RESET: state_next = ST_SETTLE;
			ST_SETTLE: begin
				// Track the straps until reset lifts
				pb_next = pb_dec; // R5
				c0_next = c0_dec;
				c1_next = c1_dec;
				if (!SRST) begin
					state_next = ST_LOCKED;
				end
			end
			ST_LOCKED: state_next = ST_LOCKED; // R5
			default:   state_next = ST_RESET;
		endcase
		// Reset reopens the window from any state, a locked one too
		if (SRST) begin
			state_next = ST_SETTLE;
		end
	end
	always_ff @(posedge CLK_SYS) begin
		state_reg <= state_next;
		pb_reg <= pb_next;
		c0_reg <= c0_next;
		c1_reg <= c1_next;
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Zero through reset so nothing downstream acts on a half-synced strap
	ratio_t pb_out_next;
	ratio_t c0_out_next;
	ratio_t c1_out_next;
	logic   locked_next;
	always_comb begin
		pb_out_next = pb_next;
		c0_out_next = c0_next;
		c1_out_next = c1_next;
		locked_next = (state_next == ST_LOCKED);
		if (SRST) begin
			pb_out_next = '{num: `PB_NUM_RESET, den: `DEN_RESET, reserved: 1'b0};
			c0_out_next = '{num: `CORE_NUM_RESET, den: `DEN_RESET, reserved: 1'b0};
			c1_out_next = '{num: `CORE_NUM_RESET, den: `DEN_RESET, reserved: 1'b0};
			locked_next = 1'b0;
		end
	end
	always_ff @(posedge CLK_SYS) begin
		PB_RATIO_NUM <= pb_out_next.num;
		PB_RATIO_RESERVED <= pb_out_next.reserved;
		CORE0_RATIO_NUM <= c0_out_next.num;
		CORE0_RATIO_DEN <= c0_out_next.den;
		CORE0_RATIO_RESERVED <= c0_out_next.reserved;
		CORE1_RATIO_NUM <= c1_out_next.num;
		CORE1_RATIO_DEN <= c1_out_next.den;
		CORE1_RATIO_RESERVED <= c1_out_next.reserved;
		RATIOS_LOCKED <= locked_next; // R5
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SRST);

	sequence locked_s;
		RATIOS_LOCKED && $past(RATIOS_LOCKED);
	endsequence

	ratio_hold_a: assert property (locked_s |-> $stable(PB_RATIO_NUM) // R5
		&& $stable(CORE0_RATIO_NUM) && $stable(CORE1_RATIO_NUM)
		&& $stable(CORE0_RATIO_DEN) && $stable(CORE1_RATIO_DEN))
		else $error("ratio changed after lock");
	lock_rise_a: assert property ($fell(SRST) |=> RATIOS_LOCKED) // R5
		else $error("lock missing after reset release");
	lock_stay_a: assert property (RATIOS_LOCKED |=> RATIOS_LOCKED) // R5
		else $error("lock dropped without reset");
	reset_clear_a: assert property (disable iff (1'b0) SRST |=> !RATIOS_LOCKED // R5
		&& PB_RATIO_NUM == `PB_NUM_RESET && CORE0_RATIO_NUM == `CORE_NUM_RESET
		&& CORE1_RATIO_NUM == `CORE_NUM_RESET)
		else $error("outputs not cleared in reset");
	pb_reserved_a: assert property (RATIOS_LOCKED // R1
		|-> PB_RATIO_RESERVED == (PB_RATIO_NUM == 5'h00))
		else $error("platform reserved flag mismatch");
	pb_twelve_a: assert property ($fell(SRST) && sync2_reg[8:6] == 3'h5 // R1
		|=> PB_RATIO_NUM == 5'h0c)
		else $error("platform 12 to 1 decode wrong");
	pb_four_a: assert property ($fell(SRST) && sync2_reg[8:6] == 3'h0 |=> PB_RATIO_NUM == 5'h04) // R1
		else $error("platform 4 to 1 decode wrong");
	core0_order_a: assert property ($fell(SRST) && sync2_reg[5:3] == 3'h4 // R2
		|=> CORE0_RATIO_NUM == 5'h02 && CORE0_RATIO_DEN == 2'h1)
		else $error("core0 strap order wrong");
	core0_low_a: assert property ($fell(SRST) && sync2_reg[5:3] < 3'h3 |=> CORE0_RATIO_RESERVED) // R3
		else $error("core0 reserved not flagged");
	core_half_a: assert property (RATIOS_LOCKED && !CORE0_RATIO_RESERVED // R3
		&& CORE0_RATIO_DEN == 2'h2 |-> CORE0_RATIO_NUM[0])
		else $error("core0 half ratio numerator even");
	core1_own_a: assert property ($fell(SRST) && sync2_reg[2:0] == 3'h4 // R4
		|=> CORE1_RATIO_NUM == 5'h02 && CORE1_RATIO_DEN == 2'h1)
		else $error("core1 ratio not its own");
	core1_low_a: assert property ($fell(SRST) && sync2_reg[2:0] < 3'h3 |=> CORE1_RATIO_RESERVED) // R4
		else $error("core1 reserved not flagged");
endmodule // power_up_clock_ratio_straps

// ---- tb/power_up_clock_ratio_straps_tb_top.sv ----
// Self-checking bench for the power-up clock ratio block
`timescale 1ns/100ps
`include "clock_ratio_defines.svh"
module power_up_clock_ratio_straps_tb_top
	import clock_ratio_pkg::*;
;
	logic       clk_sys, srst, pb_res, c0_res, c1_res, locked;
	straps_t    want, pins;
	logic [2:0] want1, pins1;
	logic [4:0] pb_num, c0_num, c1_num;
	logic [1:0] c0_den, c1_den;
	logic [24:0] note_q[$];
	logic [24:0] e;
	logic [31:0] rnd;
	int          n_fail, n_compared, seed, cycles;
	// Expected while reset is held: lock low, every ratio field at its reset value
	localparam logic [24:0] reset_note = {1'b0, `PB_NUM_RESET, 2'h0, 1'b0,
		`CORE_NUM_RESET, `DEN_RESET, 1'b0, `CORE_NUM_RESET, `DEN_RESET, 1'b0};

	strap_board_model board_u (.clk(clk_sys), .want(want), .want1(want1), .pins(pins),
		.pins1(pins1));
	power_up_clock_ratio_straps dut_u (.CLK_SYS(clk_sys), .SRST(srst),
		.LOCAL_ADDRESS_STRAP_BITS(pins.local_address_strap_bits),
		.BUS_CONTROL_STRAP(pins.bus_control_strap),
		.ADDRESS_LATCH_ENABLE_STRAP(pins.address_latch_enable_strap),
		.GENERAL_PURPOSE_LINE2_STRAP(pins.general_purpose_line2_strap),
		.CORE1_RATIO_STRAP(pins1), .PB_RATIO_NUM(pb_num), .PB_RATIO_RESERVED(pb_res),
		.CORE0_RATIO_NUM(c0_num), .CORE0_RATIO_DEN(c0_den), .CORE0_RATIO_RESERVED(c0_res),
		.CORE1_RATIO_NUM(c1_num), .CORE1_RATIO_DEN(c1_den), .CORE1_RATIO_RESERVED(c1_res),
		.RATIOS_LOCKED(locked));

	function automatic ratio_t pb_exp(logic [2:0] c);
		case (c)
			3'h0: return {5'h04, 2'h0, 1'b0};
			3'h1: return {5'h05, 2'h0, 1'b0};
			3'h2: return {5'h06, 2'h0, 1'b0};
			3'h3: return {5'h08, 2'h0, 1'b0};
			3'h4: return {5'h0a, 2'h0, 1'b0};
			3'h5: return {5'h0c, 2'h0, 1'b0};
			default: return {5'h00, 2'h0, 1'b1};
		endcase
	endfunction

	function automatic ratio_t core_exp(logic [2:0] c);
		case (c)
			3'h3: return {5'h03, 2'h2, 1'b0};
			3'h4: return {5'h02, 2'h1, 1'b0};
			3'h5: return {5'h05, 2'h2, 1'b0};
			3'h6: return {5'h03, 2'h1, 1'b0};
			3'h7: return {5'h07, 2'h2, 1'b0};
			default: return {5'h00, 2'h1, 1'b1};
		endcase
	endfunction

	task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic conclude();
		if (n_fail == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// One capture per reset; straps then wander and must be ignored
	task automatic capture(straps_t s, logic [2:0] c1);
		logic [24:0] x;
		logic [31:0] r;
		x = {1'b1, pb_exp(s[5:3]), core_exp(s[2:0]), core_exp(c1)};
		srst <= 1'b1;
		want <= s;
		want1 <= c1;
		repeat (2) @(posedge clk_sys);
		note_q.push_back(reset_note);
		repeat (3) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		note_q.push_back(x);
		@(posedge clk_sys);
		r = $random(seed);
		want <= r[5:0];
		want1 <= r[8:6];
		repeat (4) @(posedge clk_sys);
		note_q.push_back(x);
	endtask

	always @(negedge clk_sys) begin
		if (note_q.size() > 0) begin
			e = note_q.pop_front();
			chk("locked", {7'h00, locked}, {7'h00, e[24]});
			chk("platform ratio", {pb_num, 2'h0, pb_res}, e[23:16]);
			chk("core0 ratio", {c0_num, c0_den, c0_res}, e[15:8]);
			chk("core1 ratio", {c1_num, c1_den, c1_res}, e[7:0]);
		end
	end

	// Ceiling well above nine captures of about a dozen cycles each
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 1000) begin
			n_fail++;
			conclude();
		end
	end

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	initial begin
		seed = 1039;
		srst = 1'b1;
		want = '0;
		want1 = 3'h0;
		repeat (20) @(posedge clk_sys);
		for (int i = 0; i < 8; i++) begin
			capture({i[2:0], i[2:0] ^ 3'h3}, 3'h7 - i[2:0]);
		end
		rnd = $random(seed);
		capture(rnd[5:0], rnd[8:6]);
		repeat (3) @(posedge clk_sys);
		conclude();
	end
endmodule // power_up_clock_ratio_straps_tb_top

// ---- tb/strap_board_model.sv ----
// Board-side model that presents strap levels to the clock ratio block
`timescale 1ns/100ps
module strap_board_model
	import clock_ratio_pkg::*;
(
	input  wire logic       clk,
	input  wire straps_t    want,
	input  wire logic [2:0] want1,
	output straps_t         pins,
	output logic      [2:0] pins1
);
	// Levels move only just after an edge, like a reset sequencer would
	// Only straps are driven; status outputs keep their pull-ups, test select its level
	always @(posedge clk) begin
		pins <= want;
		pins1 <= want1;
	end
endmodule // strap_board_model
